// ===== rtl/external_memory_port.sv
`timescale 1ns/100ps
`include "ext_port_map.svh"
// Notes on behaviour
// - Data bus is 48 bits for instructions, 40 for extended data, 32 for single precision.
// - Packed 16- or 32-bit words are supported for DMA data.
// - 32-bit values travel on data bits 47 to 16.
// - 40-bit extended values travel on data bits 47 to 8.
// - 16-bit short words travel on data bits 31 to 16.
// - Data path reaches 4 gigawords; program path reaches only 12 megawords.
// - One active-low select per bank, switched with the address.
// - Selects idle without access; conditional accesses still assert them.
// - Page flag only on bank 0 accesses that cross a page.
// - Read strobe low while this device reads externally.
// - Write strobe low while this device writes externally.
// - Early-write flag low with the address; write abandoned without strobe.
// - Slave side uses the early-write flag to tell read from write.
// - As slave, drive acknowledge low to stall synchronous accesses.
// - Master keeps acknowledge at its last driven level.
// - Address, control and master write data float on suspend, host request or when bus slave.
// - Address pins become inputs during external master accesses.
// - Only the bus master drives selects and page flag.
// - Bank 0 starts at 0x0040_0000; four equal contiguous banks.
// - Bank size is 2 to the power of field plus 13.
// - Unbanked space above bank 3 asserts no select.
// - Acknowledge sampled each cycle; low holds the access one more cycle.
module external_memory_port
  import ext_port_pkg::*;
#(
  parameter int SLAVE_WAIT = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire ext_port_pkg::ext_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [47:0] rsp_data,
  output logic rsp_valid,
  output logic fault,
  input wire logic [3:0] bank_size_field,
  input wire logic [2:0] page_size_code,
  input wire logic is_bus_master,
  input wire logic suspend_tristate_in,
  input wire logic host_bus_request,
  output ext_port_pkg::ext_pins_s pins,
  input wire logic [31:0] addr_i,
  input wire logic [47:0] data_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic early_store_i_n,
  input wire logic ack_i,
  output ext_port_pkg::slave_req_s slv_req,
  output logic slv_valid,
  input wire logic slv_done,
  input wire logic [47:0] slv_rdata
);
  import ext_port_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_SLAVE = 3'b100
  } port_state_e;

  port_state_e state_ff, nxt_state;
  ext_req_s cur_ff, nxt_cur;
  logic [3:0] sel_ff, nxt_sel;
  logic page_ff, nxt_page;
  logic [31:0] last_addr_ff, nxt_last_addr;
  logic last_valid_ff, nxt_last_valid;
  logic [47:0] rsp_data_ff, nxt_rsp_data;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [47:0] slv_rdata_ff, nxt_slv_rdata;
  logic slv_drive_ff, nxt_slv_drive;
  logic [2:0] ack_sync_ff, rd_sync_ff, wr_sync_ff, early_sync_ff, nxt_ack_sync, nxt_rd_sync;
  logic [2:0] nxt_wr_sync, nxt_early_sync;
  // Suspend and host request pins are filtered like the strobes.
  logic [2:0] susp_sync_ff, hreq_sync_ff, nxt_susp_sync, nxt_hreq_sync;
  logic susp_lvl_ff, hreq_lvl_ff, nxt_susp_lvl, nxt_hreq_lvl;
  logic ack_keep_ff, nxt_ack_keep;
  logic rd_lvl_ff, wr_lvl_ff, early_lvl_ff, nxt_rd_lvl, nxt_wr_lvl, nxt_early_lvl;
  logic [3:0] hit;
  logic pcross;
  logic req_bad;
  logic float_bus;
  logic [47:0] lane_data;
  logic [47:0] lane_rd;

  // Only the slave acknowledge stall (1) or none (0) is built.
  if (SLAVE_WAIT < 0 || SLAVE_WAIT > 1) begin : g_bad_wait
    $error("SLAVE_WAIT must be 0 or 1");
  end

  bank_decoder #(
    .ADDR_W(32)
  ) u_dec (
    .addr(req.addr),
    .last_page_addr(last_addr_ff),
    .last_valid(last_valid_ff),
    .bank_size_field(bank_size_field),
    .page_size_code(page_size_code),
    .bank_hit(hit),
    .page_cross(pcross)
  );

  // Address, control and master write data float while suspended, while the host asks for the bus, or as slave.
  assign float_bus = susp_lvl_ff | hreq_lvl_ff | !is_bus_master;

  // Program bus addresses reach only the low 12 megawords.
  assign req_bad = req.from_prog_bus && (req.addr >= `PROG_REACH_WORDS);

  // Place outgoing data on the lanes its format uses.
  always_comb begin
    lane_data = 48'h0;
    unique case (req.fmt)
      FMT_SINGLE, FMT_PACK32: lane_data[47:`LANE_SINGLE_LSB] = req.wdata[31:0];
      FMT_EXTENDED: lane_data[47:`LANE_EXT_LSB] = req.wdata[39:0];
      FMT_SHORT, FMT_PACK16: lane_data[31:`LANE_SHORT_LSB] = req.wdata[15:0];
      FMT_INSTR: lane_data = req.wdata;
      default: lane_data = 48'h0;
    endcase
  end

  // Take incoming data off the lanes of the current format, right aligned.
  always_comb begin
    lane_rd = 48'h0;
    unique case (cur_ff.fmt)
      FMT_SINGLE, FMT_PACK32: lane_rd[31:0] = data_i[47:`LANE_SINGLE_LSB];
      FMT_EXTENDED: lane_rd[39:0] = data_i[47:`LANE_EXT_LSB];
      FMT_SHORT, FMT_PACK16: lane_rd[15:0] = data_i[31:`LANE_SHORT_LSB];
      FMT_INSTR: lane_rd = data_i;
      default: lane_rd = 48'h0;
    endcase
  end

  // Pin synchronisers: a level changes once the second and third stages agree.
  always_comb begin
    nxt_ack_sync = {ack_sync_ff[1:0], ack_i};
    nxt_rd_sync = {rd_sync_ff[1:0], rd_n_i};
    nxt_wr_sync = {wr_sync_ff[1:0], wr_n_i};
    nxt_early_sync = {early_sync_ff[1:0], early_store_i_n};
    nxt_susp_sync = {susp_sync_ff[1:0], suspend_tristate_in};
    nxt_hreq_sync = {hreq_sync_ff[1:0], host_bus_request};
    nxt_ack_keep = (ack_sync_ff[2] == ack_sync_ff[1]) ? ack_sync_ff[2] : ack_keep_ff;
    nxt_rd_lvl = (rd_sync_ff[2] == rd_sync_ff[1]) ? rd_sync_ff[2] : rd_lvl_ff;
    nxt_wr_lvl = (wr_sync_ff[2] == wr_sync_ff[1]) ? wr_sync_ff[2] : wr_lvl_ff;
    nxt_early_lvl = (early_sync_ff[2] == early_sync_ff[1]) ? early_sync_ff[2] : early_lvl_ff;
    nxt_susp_lvl = (susp_sync_ff[2] == susp_sync_ff[1]) ? susp_sync_ff[2] : susp_lvl_ff;
    nxt_hreq_lvl = (hreq_sync_ff[2] == hreq_sync_ff[1]) ? hreq_sync_ff[2] : hreq_lvl_ff;
  end

  // Out of reset the strobes read as released and the bus as not suspended.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack_sync_ff <= 3'h7;
      rd_sync_ff <= 3'h7;
      wr_sync_ff <= 3'h7;
      early_sync_ff <= 3'h7;
      susp_sync_ff <= 3'h0;
      hreq_sync_ff <= 3'h0;
      ack_keep_ff <= 1'b1;
      rd_lvl_ff <= 1'b1;
      wr_lvl_ff <= 1'b1;
      early_lvl_ff <= 1'b1;
      susp_lvl_ff <= 1'b0;
      hreq_lvl_ff <= 1'b0;
    end else begin
      ack_sync_ff <= nxt_ack_sync;
      rd_sync_ff <= nxt_rd_sync;
      wr_sync_ff <= nxt_wr_sync;
      early_sync_ff <= nxt_early_sync;
      susp_sync_ff <= nxt_susp_sync;
      hreq_sync_ff <= nxt_hreq_sync;
      ack_keep_ff <= nxt_ack_keep;
      rd_lvl_ff <= nxt_rd_lvl;
      wr_lvl_ff <= nxt_wr_lvl;
      early_lvl_ff <= nxt_early_lvl;
      susp_lvl_ff <= nxt_susp_lvl;
      hreq_lvl_ff <= nxt_hreq_lvl;
    end
  end

  // Access sequencer: master accesses, then slave accesses into internal memory.
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_sel = sel_ff;
    nxt_page = page_ff;
    nxt_last_addr = last_addr_ff;
    nxt_last_valid = last_valid_ff;
    nxt_rsp_data = rsp_data_ff;
    nxt_rsp_valid = 1'b0;
    nxt_slv_rdata = slv_rdata_ff;
    nxt_slv_drive = slv_drive_ff;
    req_ready = 1'b0;
    fault = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        nxt_sel = 4'h0;
        nxt_page = 1'b0;
        if (!is_bus_master && (!rd_lvl_ff || !wr_lvl_ff)) begin
          nxt_state = ST_SLAVE;
          nxt_slv_drive = 1'b0;
        end else if (req_valid && !float_bus) begin
          req_ready = 1'b1;
          if (req_bad) begin
            fault = 1'b1;
          end else begin
            nxt_cur = req;
            nxt_cur.wdata = lane_data;
            nxt_sel = hit;
            nxt_page = pcross;
            if (hit[0]) begin
              nxt_last_addr = req.addr;
              nxt_last_valid = 1'b1;
            end
            nxt_state = ST_ACCESS;
          end
        end
      end
      ST_ACCESS: begin
        // Acknowledge low holds everything one more cycle.
        if (ack_keep_ff) begin
          nxt_state = ST_IDLE;
          nxt_sel = 4'h0;
          nxt_page = 1'b0;
          if (!cur_ff.write) begin
            nxt_rsp_data = lane_rd;
            nxt_rsp_valid = 1'b1;
          end
        end
      end
      ST_SLAVE: begin
        if (slv_done) begin
          nxt_slv_rdata = slv_rdata;
          nxt_slv_drive = 1'b1;
        end
        if (rd_lvl_ff && wr_lvl_ff) begin
          nxt_state = ST_IDLE;
          nxt_slv_drive = 1'b0;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Registers the sequencer; reset leaves the port idle with nothing selected.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      sel_ff <= 4'h0;
      page_ff <= 1'b0;
      last_addr_ff <= 32'h0;
      last_valid_ff <= 1'b0;
      rsp_data_ff <= 48'h0;
      rsp_valid_ff <= 1'b0;
      slv_rdata_ff <= 48'h0;
      slv_drive_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      sel_ff <= nxt_sel;
      page_ff <= nxt_page;
      last_addr_ff <= nxt_last_addr;
      last_valid_ff <= nxt_last_valid;
      rsp_data_ff <= nxt_rsp_data;
      rsp_valid_ff <= nxt_rsp_valid;
      slv_rdata_ff <= nxt_slv_rdata;
      slv_drive_ff <= nxt_slv_drive;
    end
  end

  // Read data and its pulse come straight from flip-flops.
  assign rsp_data = rsp_data_ff;
  assign rsp_valid = rsp_valid_ff;

  // Slave request toward internal memory; the early-write level tells direction.
  assign slv_req.addr = addr_i;
  assign slv_req.wdata = data_i;
  assign slv_req.write = !early_lvl_ff || !wr_lvl_ff;
  assign slv_valid = (state_ff == ST_SLAVE) && !slv_drive_ff;

  // Outgoing pins; strobes and selects exist only during a master access.
  always_comb begin
    pins.addr_o = cur_ff.addr;
    pins.addr_oe = (state_ff == ST_ACCESS) && !float_bus;
    pins.data_o = (state_ff == ST_SLAVE) ? slv_rdata_ff : cur_ff.wdata;
    pins.data_oe = ((state_ff == ST_ACCESS) && cur_ff.write && !float_bus) ||
                   ((state_ff == ST_SLAVE) && slv_drive_ff && !rd_lvl_ff);
    pins.bank_select_n = ~sel_ff;
    pins.rd_n_o = !((state_ff == ST_ACCESS) && !cur_ff.write);
    // The write strobe drops only if the condition held; else the write is dropped.
    pins.wr_n_o = !((state_ff == ST_ACCESS) && cur_ff.write && cur_ff.cond_true);
    pins.early_store_flag_n = !((state_ff == ST_ACCESS) && cur_ff.write);
    pins.page = page_ff;
    pins.ctl_oe = !float_bus;
    // As slave, hold acknowledge low until internal memory answers.
    pins.ack_o = 1'b0;
    pins.ack_oe = (SLAVE_WAIT == 1) && (state_ff == ST_SLAVE) && !slv_drive_ff;
  end
endmodule // external_memory_port

// ===== shared/ext_port_map.svh
`ifndef EXT_PORT_MAP_SVH
`define EXT_PORT_MAP_SVH
// Base of external bank 0, in words.
`define BANK0_BASE 32'h0040_0000
// Bank size code offset: bank size is 2 to the power of (code + this).
`define BANK_SIZE_BIAS 13
// Largest legal bank size code (256 megawords).
`define BANK_SIZE_CODE_MAX 4'hf
// Program bus address width and its reach in words (12 megawords).
`define PROG_ADDR_BITS 24
`define PROG_REACH_WORDS 32'h00c0_0000
// Data lane positions on the 48-bit external bus.
`define LANE_SINGLE_LSB 16
`define LANE_EXT_LSB 8
`define LANE_SHORT_LSB 16
// Reset value of the bank size code.
`define BANK_SIZE_RESET 4'h0
`define PAGE_SIZE_RESET 3'h0
`endif

// ===== shared/ext_port_pkg.sv
package ext_port_pkg;
  // Width of a word as seen by the core.
  typedef enum logic [2:0] {
    FMT_SINGLE = 3'h0,
    FMT_EXTENDED = 3'h1,
    FMT_SHORT = 3'h2,
    FMT_INSTR = 3'h3,
    FMT_PACK16 = 3'h4,
    FMT_PACK32 = 3'h5
  } word_fmt_e;

  // One request from the core or the I/O processor.
  typedef struct packed {
    logic [31:0] addr;
    logic [47:0] wdata;
    logic write;
    logic from_prog_bus;
    logic cond_true;
    word_fmt_e fmt;
  } ext_req_s;

  // Pins toward the external bus; address, data and acknowledge have their own output enable, the controls share ctl_oe.
  typedef struct packed {
    logic [31:0] addr_o;
    logic addr_oe;
    logic [47:0] data_o;
    logic data_oe;
    logic [3:0] bank_select_n;
    logic rd_n_o;
    logic wr_n_o;
    logic early_store_flag_n;
    logic page;
    logic ctl_oe;
    logic ack_o;
    logic ack_oe;
  } ext_pins_s;

  // Access arriving from an external master into internal memory.
  typedef struct packed {
    logic [31:0] addr;
    logic [47:0] wdata;
    logic write;
  } slave_req_s;
endpackage

// ===== rtl/bank_decoder.sv
`timescale 1ns/100ps
`include "ext_port_map.svh"
// Decodes a word address into a bank number and a page-crossing flag.
module bank_decoder #(
  parameter int ADDR_W = 32
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [ADDR_W-1:0] last_page_addr,
  input wire logic last_valid,
  input wire logic [3:0] bank_size_field,
  input wire logic [2:0] page_size_code,
  output logic [3:0] bank_hit,
  output logic page_cross
);
  logic [ADDR_W-1:0] rel;
  logic [5:0] shift;
  logic [ADDR_W-1:0] bank_idx;
  logic [5:0] pshift;

  // Only a full 32-bit word address is decoded.
  if (ADDR_W != 32) begin : g_bad_addr_w
    $error("bank_decoder needs a 32-bit address");
  end

  // Banks are equal powers of two laid end to end above the base.
  always_comb begin
    rel = addr - `BANK0_BASE;
    shift = 6'(bank_size_field) + 6'(`BANK_SIZE_BIAS);
    bank_idx = rel >> shift;
    bank_hit = 4'h0;
    if (addr >= `BANK0_BASE && bank_idx < 32'h4) begin
      bank_hit[bank_idx[1:0]] = 1'b1;
    end
    // Anything above bank 3 selects nothing.
    pshift = 6'h8 + 6'(page_size_code);
    page_cross = bank_hit[0] &&
                 (!last_valid || ((addr >> pshift) != (last_page_addr >> pshift)));
  end
endmodule // bank_decoder

// ===== verif/ext_mem_model.sv
`timescale 1ns/100ps
// Stands in for external SRAM; it can hold acknowledge low to stretch accesses.
module ext_mem_model (
  input wire logic clk_sys,
  input wire ext_port_pkg::ext_pins_s pins,
  input wire logic [3:0] waits,
  output logic ack_i,
  output logic [47:0] data_i
);
  import ext_port_pkg::*;
  logic [47:0] mem [256] = '{default: 48'h0};
  logic [47:0] junk = 48'h5555_aaaa_5555;
  logic [3:0] cnt = 4'h0;
  logic act;
  // The model answers only while the port drives a strobe.
  assign act = pins.ctl_oe && !(pins.rd_n_o && pins.wr_n_o);
  // Acknowledge stays low until the access has lasted the set number of cycles.
  assign ack_i = (cnt >= waits);
  // Released data lines show a changing pattern, never the last word.
  assign data_i = (act && !pins.rd_n_o) ? mem[pins.addr_o[7:0]] : junk;
  // Counts strobe cycles and stores written words whole.
  always @(posedge clk_sys) begin
    junk <= ~junk;
    cnt <= act ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
    if (act && !pins.wr_n_o) begin
      mem[pins.addr_o[7:0]] <= pins.data_o;
    end
  end
endmodule // ext_mem_model

// ===== verif/external_memory_port_properties.sv
`timescale 1ns/100ps
// Watches the pins of the external port against its bus protocol.
module external_memory_port_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire ext_port_pkg::ext_req_s req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic fault,
  input wire logic rsp_valid,
  input wire logic is_bus_master,
  input wire logic suspend_tristate_in,
  input wire logic host_bus_request,
  input wire ext_port_pkg::ext_pins_s pins,
  input wire logic slv_valid,
  input wire logic slv_done
);
  import ext_port_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic flt;
  // Any cause that must float the port.
  assign flt = suspend_tristate_in || host_bus_request || !is_bus_master;
  // A request taken without a fault.
  sequence s_take;
    req_valid && req_ready && !fault;
  endsequence
  a_float_oe: assert property (flt [*5] |-> !pins.ctl_oe && !pins.addr_oe)
    else $error("outputs driven while floating");
  a_float_refuse: assert property (flt [*5] |-> !req_ready)
    else $error("request taken while floating");
  a_strobe_excl: assert property (!(!pins.rd_n_o && !pins.wr_n_o))
    else $error("both strobes low");
  a_flag_first: assert property ($fell(pins.wr_n_o) |-> !pins.early_store_flag_n)
    else $error("write strobe without early flag");
  a_page_bank0: assert property (pins.page && pins.ctl_oe |-> !pins.bank_select_n[0])
    else $error("page flag outside bank 0");
  a_one_select: assert property ($onehot0(~pins.bank_select_n))
    else $error("several selects low");
  a_read_start: assert property (s_take ##0 !req.write |=> !pins.rd_n_o)
    else $error("read strobe missing");
  a_write_start: assert property (s_take ##0 req.write |=> !pins.early_store_flag_n)
    else $error("early flag missing");
  a_fault_quiet: assert property (req_ready && fault |=> pins.rd_n_o && pins.wr_n_o)
    else $error("faulted request reached the bus");
  a_rsp_read: assert property (rsp_valid |-> !$past(pins.rd_n_o) ##1 !rsp_valid)
    else $error("read data without read");
  a_slave_ack: assert property (slv_valid && $past(slv_valid) && !slv_done |->
    pins.ack_oe && !pins.ack_o)
    else $error("slave not holding acknowledge low");
endmodule // external_memory_port_properties

bind external_memory_port external_memory_port_properties u_props (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .req(req),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .fault(fault),
  .rsp_valid(rsp_valid),
  .is_bus_master(is_bus_master),
  .suspend_tristate_in(suspend_tristate_in),
  .host_bus_request(host_bus_request),
  .pins(pins),
  .slv_valid(slv_valid),
  .slv_done(slv_done)
);

// ===== verif/external_memory_port_test.sv
`timescale 1ns/100ps
// Drives the external memory port against a memory model and checks its pins.
module external_memory_port_test;
  import ext_port_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  ext_req_s req = '0;
  logic req_valid = 1'b0;
  logic [3:0] bank_size_field = 4'h0;
  logic [2:0] page_size_code = 3'h0;
  logic is_bus_master = 1'b1;
  logic suspend_tristate_in = 1'b0;
  logic host_bus_request = 1'b0;
  logic [31:0] addr_i = 32'h0000_0123;
  logic rd_n_i = 1'b1;
  logic wr_n_i = 1'b1;
  logic early_store_i_n = 1'b1;
  logic slv_done = 1'b0;
  logic [47:0] slv_rdata = 48'h1234_5678_9abc;
  logic [3:0] waits = 4'h0;
  logic req_ready, rsp_valid, fault, slv_valid, ack_i, flt, rv, sawwr;
  logic [47:0] rsp_data, data_i, rd;
  ext_pins_s pins, snap;
  slave_req_s slv_req;
  int num_errors = 0;
  int tests_run = 0;
  int len;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  external_memory_port u_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .req(req),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .rsp_data(rsp_data),
    .rsp_valid(rsp_valid),
    .fault(fault),
    .bank_size_field(bank_size_field),
    .page_size_code(page_size_code),
    .is_bus_master(is_bus_master),
    .suspend_tristate_in(suspend_tristate_in),
    .host_bus_request(host_bus_request),
    .pins(pins),
    .addr_i(addr_i),
    .data_i(data_i),
    .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i),
    .early_store_i_n(early_store_i_n),
    .ack_i(ack_i),
    .slv_req(slv_req),
    .slv_valid(slv_valid),
    .slv_done(slv_done),
    .slv_rdata(slv_rdata)
  );
  ext_mem_model u_mem (
    .clk_sys(clk_sys),
    .pins(pins),
    .waits(waits),
    .ack_i(ack_i),
    .data_i(data_i)
  );
  // Compares one value and counts it.
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Issues one request and records the pins of its first bus cycle.
  task automatic acc(input logic [31:0] a, input logic [47:0] w, input logic wr,
                     input word_fmt_e f, input logic c, input logic pb);
    @(negedge clk_sys);
    req = '{a, w, wr, pb, c, f};
    req_valid = 1'b1;
    #1;
    for (int i = 0; i < 40 && req_ready !== 1'b1; i++) begin
      @(negedge clk_sys);
      #1;
    end
    flt = fault;
    @(negedge clk_sys);
    req_valid = 1'b0;
    snap = pins;
    sawwr = 1'b0;
    for (len = 0; len < 40 && !(pins.rd_n_o && pins.wr_n_o && pins.early_store_flag_n); len++) begin
      sawwr |= !pins.wr_n_o;
      @(negedge clk_sys);
    end
    rv = rsp_valid;
    rd = rsp_data;
  endtask
  // Writes and reads back each word format and checks its lanes.
  task automatic t_lanes();
    word_fmt_e f [6] = '{FMT_SINGLE, FMT_EXTENDED, FMT_SHORT, FMT_INSTR, FMT_PACK32, FMT_PACK16};
    int wb [6] = '{32, 40, 16, 48, 32, 16};
    int lb [6] = '{16, 8, 16, 0, 16, 16};
    logic [47:0] w, m;
    w = 48'ha1b2_c3d4_e5f6;
    for (int k = 0; k < 6; k++) begin
      m = (48'h1 << wb[k]) - 48'h1;
      acc(32'h0040_0010, w, 1'b1, f[k], 1'b1, 1'b0);
      check(snap.wr_n_o, 1'b0);
      check(snap.early_store_flag_n, 1'b0);
      check(snap.data_oe, 1'b1);
      check((snap.data_o >> lb[k]) & m, w & m);
      acc(32'h0040_0010, 48'h0, 1'b0, f[k], 1'b1, 1'b0);
      check(snap.rd_n_o, 1'b0);
      check(snap.data_oe, 1'b0);
      check(len < 3, 1'b1);
      check(rv, 1'b1);
      check(rd, w & m);
    end
    $display("lanes test done");
  endtask
  // Walks the banks for two bank sizes, then page crossings in bank 0.
  task automatic t_banks();
    for (int s = 0; s < 4; s += 3) begin
      bank_size_field = 4'(s);
      for (int k = 0; k < 5; k++) begin
        acc(32'h0040_0000 + (32'(k) << (13 + s)), 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b0);
        check(snap.bank_select_n, (k < 4) ? 4'(~(4'h1 << k)) : 4'hf);
        check(snap.addr_o, 32'h0040_0000 + (32'(k) << (13 + s)));
        if (k > 0) check(snap.page, 1'b0);
        check(pins.bank_select_n, 4'hf);
      end
    end
    bank_size_field = 4'h0;
    acc(32'h0040_0010, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b0);
    acc(32'h0040_0020, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b0);
    check(snap.page, 1'b0);
    acc(32'h0040_0120, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b0);
    check(snap.page, 1'b1);
    $display("bank test done");
  endtask
  // A conditional write whose condition fails still selects its bank.
  task automatic t_cond();
    acc(32'h0040_2000, 48'h5, 1'b1, FMT_SINGLE, 1'b0, 1'b0);
    check(snap.bank_select_n, 4'hd);
    check(snap.early_store_flag_n, 1'b0);
    check(sawwr, 1'b0);
    $display("conditional test done");
  endtask
  // Program bus reach ends below 12 megawords; the data bus goes further.
  task automatic t_fault();
    acc(32'h00c0_0000, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b1);
    check(flt, 1'b1);
    check(snap.rd_n_o, 1'b1);
    acc(32'h00bf_fff0, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b1);
    check(flt, 1'b0);
    acc(32'h00c0_0000, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b0);
    check(flt, 1'b0);
    $display("fault test done");
  endtask
  // A slow memory stretches the access until acknowledge returns high.
  task automatic t_wait();
    waits = 4'h5;
    repeat (6) @(negedge clk_sys);
    acc(32'h0040_0010, 48'h0, 1'b0, FMT_SINGLE, 1'b1, 1'b0);
    check(len > 5, 1'b1);
    check(rv, 1'b1);
    waits = 4'h0;
    repeat (6) @(negedge clk_sys);
    $display("wait test done");
  endtask
  // Suspend and host request each float the port and refuse requests.
  task automatic t_float();
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_sys);
      suspend_tristate_in = (k == 0);
      host_bus_request = (k == 1);
      repeat (6) @(negedge clk_sys);
      req_valid = 1'b1;
      repeat (3) @(negedge clk_sys);
      check(pins.ctl_oe, 1'b0);
      check(pins.addr_oe, 1'b0);
      check(req_ready, 1'b0);
      req_valid = 1'b0;
      suspend_tristate_in = 1'b0;
      host_bus_request = 1'b0;
      repeat (6) @(negedge clk_sys);
      check(pins.ctl_oe, 1'b1);
    end
    $display("float test done");
  endtask
  // Another master reads and writes internal memory through this port as a slave.
  task automatic t_slave();
    is_bus_master = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(pins.ctl_oe, 1'b0);
    check(pins.addr_oe, 1'b0);
    rd_n_i = 1'b0;
    for (int k = 0; k < 20 && slv_valid !== 1'b1; k++) @(negedge clk_sys);
    check(slv_valid, 1'b1);
    check(slv_req.addr, addr_i);
    check(slv_req.write, 1'b0);
    @(negedge clk_sys);
    check(pins.ack_oe, 1'b1);
    check(pins.ack_o, 1'b0);
    slv_done = 1'b1;
    @(negedge clk_sys);
    slv_done = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(pins.data_oe, 1'b1);
    check(pins.data_o, slv_rdata);
    rd_n_i = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(pins.data_oe, 1'b0);
    early_store_i_n = 1'b0;
    wr_n_i = 1'b0;
    for (int k = 0; k < 20 && slv_valid !== 1'b1; k++) @(negedge clk_sys);
    check(slv_valid, 1'b1);
    check(slv_req.write, 1'b1);
    check(slv_req.wdata, data_i);
    check(pins.data_oe, 1'b0);
    slv_done = 1'b1;
    @(negedge clk_sys);
    slv_done = 1'b0;
    check(slv_valid, 1'b0);
    check(pins.ack_oe, 1'b0);
    wr_n_i = 1'b1;
    early_store_i_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(slv_valid, 1'b0);
    is_bus_master = 1'b1;
    $display("slave test done");
  endtask
  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    t_lanes();
    t_banks();
    t_cond();
    t_fault();
    t_wait();
    t_float();
    t_slave();
    print_verdict();
  end
endmodule // external_memory_port_test
